// ===== hdl/flash_host_defines.svh
// Offsets, field positions, command words and timing counts for the flash status host
`ifndef FLASH_HOST_DEFINES_SVH
`define FLASH_HOST_DEFINES_SVH

`define ADDR_W 19
`define DATA_W 16

// Status bit positions on the data lines
`define BIT_POLL 7
`define BIT_TOGGLE1 6
`define BIT_TLIMIT 5
`define BIT_WINDOW 3
`define BIT_TOGGLE2 2

// Command cycle addresses and data words
`define UNLOCK_ADDR1 19'h00555
`define UNLOCK_ADDR2 19'h002AA
`define CMD_UNLOCK1 16'h00AA
`define CMD_UNLOCK2 16'h0055
`define CMD_PROGRAM 16'h00A0
`define CMD_ERASE_SETUP 16'h0080
`define CMD_SECTOR_ERASE 16'h0030
`define CMD_CHIP_ERASE 16'h0010
`define CMD_SUSPEND 16'h00B0
`define CMD_RESUME 16'h0030
`define CMD_RESET 16'h00F0

// Times in ns and derived cycle counts at the system clock
`define T_CLK_NS 5
`define T_ACC_NS 150
`define T_WP_NS 50
`define T_GAP_NS 20
`define T_SKIP_NS 50000
`define CEIL_CYC(ns) (((ns) + `T_CLK_NS - 1) / `T_CLK_NS)
`define FLOOR_CYC(ns) ((ns) / `T_CLK_NS)
`define RD_CYCLES `CEIL_CYC(`T_ACC_NS)
`define WP_CYCLES `CEIL_CYC(`T_WP_NS)
`define GAP_CYCLES `CEIL_CYC(`T_GAP_NS)
`define SKIP_CYCLES `FLOOR_CYC(`T_SKIP_NS)
`define GAP_SAT 16'hFFFF

`endif

// ===== hdl/flash_host_pkg.sv
// Types shared by the flash status host and its bus cycle engine
package flash_host_pkg;

	typedef enum logic [3:0] {
		OP_READ = 4'h0,
		OP_PROGRAM = 4'h1,
		OP_SECTOR_ERASE = 4'h2,
		OP_ADD_SECTOR = 4'h3,
		OP_CHIP_ERASE = 4'h4,
		OP_SUSPEND = 4'h5,
		OP_RESUME = 4'h6,
		OP_WAIT = 4'h7,
		OP_RESET = 4'h8
	} op_t;

	typedef enum logic [3:0] {
		H_IDLE = 4'h0,
		H_SEQ = 4'h1,
		H_RD_A = 4'h2,
		H_RD_B = 4'h3,
		H_RD_C = 4'h4,
		H_RD_D = 4'h5,
		H_PRE3 = 4'h6,
		H_POST3 = 4'h7,
		H_READ = 4'h8,
		H_FIN = 4'h9
	} host_state_t;

	typedef enum logic [1:0] {
		CY_IDLE = 2'h0,
		CY_SETUP = 2'h1,
		CY_STROBE = 2'h2,
		CY_GAP = 2'h3
	} cycle_state_t;

	typedef struct packed {
		cycle_state_t state;
		logic wr;
		logic [5:0] cnt;
		logic [18:0] addr;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic dq_oe;
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic done;
	} cycle_reg_t;

	typedef struct packed {
		host_state_t state;
		op_t op;
		logic [18:0] addr;
		logic [15:0] data;
		logic [2:0] idx;
		logic issued;
		logic start;
		logic wr;
		logic [18:0] bus_addr;
		logic [15:0] bus_wdata;
		logic tog;
		logic chk;
		logic [15:0] gap;
		logic cmd_ready;
		logic done;
		logic failed;
		logic rejected;
		logic [15:0] rd_data;
		logic dev_busy;
	} host_reg_t;

endpackage

// ===== hdl/flash_bus_cycle.sv
// One asynchronous flash read or write cycle on the device pins
`timescale 1ns/1ps
`include "flash_host_defines.svh"

module flash_bus_cycle (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic start,
	input wire logic wr,
	input wire logic [18:0] addr,
	input wire logic [15:0] wdata,
	output logic [15:0] rdata,
	output logic cyc_done,
	output logic [18:0] flash_addr,
	output logic [15:0] flash_dq_out,
	output logic flash_dq_oe,
	input wire logic [15:0] flash_dq_in,
	output logic flash_ce_n,
	output logic flash_oe_n,
	output logic flash_we_n
);

	flash_host_pkg::cycle_reg_t st;
	flash_host_pkg::cycle_reg_t next_st;

	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		case (st.state)
			flash_host_pkg::CY_IDLE: begin
				// Start while busy is ignored; the host waits for done first
				if (start) begin
					next_st.state = flash_host_pkg::CY_SETUP;
					next_st.wr = wr;
					next_st.addr = addr;
					next_st.wdata = wdata;
					next_st.ce_n = 1'b0;
					next_st.dq_oe = wr;
				end
			end
			flash_host_pkg::CY_SETUP: begin
				next_st.state = flash_host_pkg::CY_STROBE;
				next_st.cnt = st.wr ? 6'(`WP_CYCLES - 1) : 6'(`RD_CYCLES - 1);
				next_st.we_n = !st.wr;
				next_st.oe_n = st.wr;
			end
			flash_host_pkg::CY_STROBE: begin
				if (st.cnt == 6'h00) begin
					if (!st.wr) begin
						next_st.rdata = flash_dq_in;
					end
					next_st.state = flash_host_pkg::CY_GAP;
					next_st.cnt = 6'(`GAP_CYCLES - 1);
					next_st.we_n = 1'b1;
					next_st.oe_n = 1'b1;
					next_st.ce_n = 1'b1;
				end else begin
					next_st.cnt = st.cnt - 6'h01;
				end
			end
			flash_host_pkg::CY_GAP: begin
				// Address and data held through the gap to cover hold times
				if (st.cnt == 6'h00) begin
					next_st.state = flash_host_pkg::CY_IDLE;
					next_st.dq_oe = 1'b0;
					next_st.done = 1'b1;
				end else begin
					next_st.cnt = st.cnt - 6'h01;
				end
			end
			default: begin
				next_st.state = flash_host_pkg::CY_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
			st.ce_n <= 1'b1;
			st.oe_n <= 1'b1;
			st.we_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign rdata = st.rdata;
	assign cyc_done = st.done;
	assign flash_addr = st.addr;
	assign flash_dq_out = st.wdata;
	assign flash_dq_oe = st.dq_oe;
	assign flash_ce_n = st.ce_n;
	assign flash_oe_n = st.oe_n;
	assign flash_we_n = st.we_n;

endmodule

// ===== hdl/flash_status_host.sv
// Host controller: issues flash commands and follows the write status bits
//
// Functional notes
// - After a timing-limit failure the host writes the reset command to return to array read.
// - The host may skip window-flag checks when added sector commands are under 50 us apart.
// - The host confirms acceptance by toggle, then checks the window flag before and after each added sector issued 50 us or more after the previous one.
// - Status polls are made at the program address or an address inside a sector being erased; the pre-add window-flag read uses the new sector's address.
`timescale 1ns/1ps
`include "flash_host_defines.svh"

module flash_status_host #(
	parameter int SKIP_CYCLES = `SKIP_CYCLES
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic cmd_valid,
	input wire flash_host_pkg::op_t cmd_op,
	input wire logic [18:0] cmd_addr,
	input wire logic [15:0] cmd_data,
	output logic cmd_ready,
	output logic done,
	output logic failed,
	output logic rejected,
	output logic [15:0] rd_data,
	output logic dev_busy,
	output logic [18:0] flash_addr,
	output logic [15:0] flash_dq_out,
	output logic flash_dq_oe,
	input wire logic [15:0] flash_dq_in,
	output logic flash_ce_n,
	output logic flash_oe_n,
	output logic flash_we_n,
	input wire logic ready_busy_output
);

	flash_host_pkg::host_reg_t st;
	flash_host_pkg::host_reg_t next_st;
	logic [15:0] bus_rdata;
	logic cyc_done;
	logic [35:0] word;
	logic toggled;

	// Command word at step idx: {last, address, data}
	function automatic logic [35:0] seq_word(input flash_host_pkg::op_t op, input logic [2:0] idx,
		input logic [18:0] a, input logic [15:0] d);
		logic [35:0] w;
		w = {1'b1, a, `CMD_RESET};
		case (op)
			flash_host_pkg::OP_PROGRAM: begin
				case (idx)
					3'h0: w = {1'b0, `UNLOCK_ADDR1, `CMD_UNLOCK1};
					3'h1: w = {1'b0, `UNLOCK_ADDR2, `CMD_UNLOCK2};
					3'h2: w = {1'b0, `UNLOCK_ADDR1, `CMD_PROGRAM};
					default: w = {1'b1, a, d};
				endcase
			end
			flash_host_pkg::OP_SECTOR_ERASE, flash_host_pkg::OP_CHIP_ERASE: begin
				case (idx)
					3'h0: w = {1'b0, `UNLOCK_ADDR1, `CMD_UNLOCK1};
					3'h1: w = {1'b0, `UNLOCK_ADDR2, `CMD_UNLOCK2};
					3'h2: w = {1'b0, `UNLOCK_ADDR1, `CMD_ERASE_SETUP};
					3'h3: w = {1'b0, `UNLOCK_ADDR1, `CMD_UNLOCK1};
					3'h4: w = {1'b0, `UNLOCK_ADDR2, `CMD_UNLOCK2};
					default: begin
						if (op == flash_host_pkg::OP_CHIP_ERASE) begin
							w = {1'b1, `UNLOCK_ADDR1, `CMD_CHIP_ERASE};
						end else begin
							w = {1'b1, a, `CMD_SECTOR_ERASE};
						end
					end
				endcase
			end
			flash_host_pkg::OP_ADD_SECTOR: w = {1'b1, a, `CMD_SECTOR_ERASE};
			flash_host_pkg::OP_SUSPEND: w = {1'b1, a, `CMD_SUSPEND};
			flash_host_pkg::OP_RESUME: w = {1'b1, a, `CMD_RESUME};
			default: w = {1'b1, a, `CMD_RESET};
		endcase
		return w;
	endfunction

	flash_bus_cycle u_cycle (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.start(st.start),
		.wr(st.wr),
		.addr(st.bus_addr),
		.wdata(st.bus_wdata),
		.rdata(bus_rdata),
		.cyc_done(cyc_done),
		.flash_addr(flash_addr),
		.flash_dq_out(flash_dq_out),
		.flash_dq_oe(flash_dq_oe),
		.flash_dq_in(flash_dq_in),
		.flash_ce_n(flash_ce_n),
		.flash_oe_n(flash_oe_n),
		.flash_we_n(flash_we_n)
	);

	assign word = seq_word(st.op, st.idx, st.addr, st.data);
	assign toggled = bus_rdata[`BIT_TOGGLE1] != st.tog;

	always_comb begin
		next_st = st;
		next_st.start = 1'b0;
		next_st.done = 1'b0;
		next_st.dev_busy = !ready_busy_output;
		next_st.gap = (st.gap == `GAP_SAT) ? st.gap : st.gap + 16'h0001;
		// Every bus cycle is launched once, then the state waits for its done
		if (st.state != flash_host_pkg::H_IDLE && st.state != flash_host_pkg::H_FIN && !st.issued) begin
			next_st.start = 1'b1;
			next_st.issued = 1'b1;
			next_st.wr = st.state == flash_host_pkg::H_SEQ;
			// Status reads stay at the latched program or sector address
			next_st.bus_addr = (st.state == flash_host_pkg::H_SEQ) ? word[34:16] : st.addr;
			next_st.bus_wdata = word[15:0];
		end
		if (cyc_done && st.issued) begin
			next_st.issued = 1'b0;
			if (!st.wr) begin
				next_st.rd_data = bus_rdata;
			end
		end
		case (st.state)
			flash_host_pkg::H_IDLE: begin
				if (cmd_valid) begin
					next_st.op = cmd_op;
					next_st.addr = cmd_addr;
					next_st.data = cmd_data;
					next_st.idx = 3'h0;
					next_st.failed = 1'b0;
					next_st.rejected = 1'b0;
					next_st.chk = st.gap >= 16'(SKIP_CYCLES);
					case (cmd_op)
						flash_host_pkg::OP_READ: next_st.state = flash_host_pkg::H_READ;
						flash_host_pkg::OP_WAIT: next_st.state = flash_host_pkg::H_RD_A;
						flash_host_pkg::OP_ADD_SECTOR: begin
							// Close spacing lets the window checks be skipped
							next_st.state = (st.gap >= 16'(SKIP_CYCLES)) ? flash_host_pkg::H_PRE3
								: flash_host_pkg::H_SEQ;
						end
						default: next_st.state = flash_host_pkg::H_SEQ;
					endcase
				end
			end
			flash_host_pkg::H_SEQ: begin
				if (cyc_done && st.issued) begin
					if (!word[35]) begin
						next_st.idx = st.idx + 3'h1;
					end else begin
						next_st.idx = 3'h0;
						case (st.op)
							flash_host_pkg::OP_SECTOR_ERASE: begin
								next_st.gap = 16'h0000;
								next_st.state = flash_host_pkg::H_RD_A;
							end
							flash_host_pkg::OP_ADD_SECTOR: begin
								next_st.gap = 16'h0000;
								next_st.state = st.chk ? flash_host_pkg::H_POST3 : flash_host_pkg::H_FIN;
							end
							flash_host_pkg::OP_RESET, flash_host_pkg::OP_READ,
							flash_host_pkg::OP_WAIT: next_st.state = flash_host_pkg::H_FIN;
							default: next_st.state = flash_host_pkg::H_RD_A;
						endcase
					end
				end
			end
			flash_host_pkg::H_RD_A, flash_host_pkg::H_RD_C: begin
				if (cyc_done && st.issued) begin
					next_st.tog = bus_rdata[`BIT_TOGGLE1];
					next_st.state = (st.state == flash_host_pkg::H_RD_A) ? flash_host_pkg::H_RD_B
						: flash_host_pkg::H_RD_D;
				end
			end
			flash_host_pkg::H_RD_B: begin
				if (cyc_done && st.issued) begin
					if (st.op == flash_host_pkg::OP_SECTOR_ERASE) begin
						// No toggle right after the sequence means it was not taken
						next_st.rejected = !toggled;
						next_st.state = flash_host_pkg::H_FIN;
					end else if (!toggled) begin
						next_st.state = flash_host_pkg::H_FIN;
					end else if (bus_rdata[`BIT_TLIMIT]) begin
						// Toggle may stop just as the limit flag rises, so look twice more
						next_st.state = flash_host_pkg::H_RD_C;
					end else begin
						next_st.state = flash_host_pkg::H_RD_A;
					end
				end
			end
			flash_host_pkg::H_RD_D: begin
				if (cyc_done && st.issued) begin
					if (toggled) begin
						next_st.failed = 1'b1;
						next_st.op = flash_host_pkg::OP_RESET;
						next_st.idx = 3'h0;
						next_st.state = flash_host_pkg::H_SEQ;
					end else begin
						next_st.state = flash_host_pkg::H_FIN;
					end
				end
			end
			flash_host_pkg::H_PRE3: begin
				if (cyc_done && st.issued) begin
					// Erase already under way: further sectors would be dropped
					next_st.rejected = bus_rdata[`BIT_WINDOW];
					next_st.state = bus_rdata[`BIT_WINDOW] ? flash_host_pkg::H_FIN : flash_host_pkg::H_SEQ;
				end
			end
			flash_host_pkg::H_POST3: begin
				if (cyc_done && st.issued) begin
					next_st.rejected = bus_rdata[`BIT_WINDOW];
					next_st.state = flash_host_pkg::H_FIN;
				end
			end
			flash_host_pkg::H_READ: begin
				if (cyc_done && st.issued) begin
					next_st.state = flash_host_pkg::H_FIN;
				end
			end
			flash_host_pkg::H_FIN: begin
				next_st.done = 1'b1;
				next_st.state = flash_host_pkg::H_IDLE;
			end
			default: begin
				next_st.state = flash_host_pkg::H_IDLE;
			end
		endcase
		next_st.cmd_ready = next_st.state == flash_host_pkg::H_IDLE;
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
			st.gap <= `GAP_SAT;
			st.cmd_ready <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign cmd_ready = st.cmd_ready;
	assign done = st.done;
	assign failed = st.failed;
	assign rejected = st.rejected;
	assign rd_data = st.rd_data;
	assign dev_busy = st.dev_busy;

	AST_FAIL_SENDS_RESET: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$rose(st.failed) |-> ##[1:4] (st.start && st.wr && st.bus_wdata == `CMD_RESET))
		else $error("timing-limit failure not followed by reset command");

	AST_FAIL_ONLY_WITH_LIMIT: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$rose(st.failed) |-> $past(st.state) == flash_host_pkg::H_RD_D && $past(toggled))
		else $error("failure flagged without a second toggling pair");

	AST_SPACED_ADD_CHECKS: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(st.state == flash_host_pkg::H_IDLE && cmd_valid && cmd_op == flash_host_pkg::OP_ADD_SECTOR)
		|=> (st.state == flash_host_pkg::H_PRE3) == ($past(st.gap) >= 16'(SKIP_CYCLES)))
		else $error("window pre-check choice does not match command spacing");

	AST_POST_CHECK: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(st.state == flash_host_pkg::H_SEQ && st.op == flash_host_pkg::OP_ADD_SECTOR && st.chk
			&& cyc_done && st.issued)
		|=> st.state == flash_host_pkg::H_POST3 ##1 (st.start && !st.wr))
		else $error("added sector not followed by window flag read");

	AST_POLL_ADDR: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(st.start && !st.wr) |-> st.bus_addr == st.addr)
		else $error("status read away from the latched valid address");

endmodule

// ===== sim/flash_device_model.sv
// Behavioural flash device answering the status host's bus cycles
`timescale 1ns/1ps
module flash_device_model #(
	parameter int PROG_CYC = 100,
	parameter int WIN_CYC = 300,
	parameter int ERASE_CYC = 600
) (
	input wire logic clk_sys,
	input wire logic [18:0] flash_addr,
	input wire logic [15:0] flash_dq_out,
	input wire logic flash_dq_oe,
	input wire logic flash_ce_n,
	input wire logic flash_oe_n,
	input wire logic flash_we_n,
	output logic [15:0] flash_dq_in,
	output logic ready_busy_output
);
	typedef enum logic [2:0] {ARRAY, PROG, WINDOW, ERASING, SUSP} dev_mode_t;
	dev_mode_t mode = ARRAY;
	logic [15:0] mem [0:255];
	logic [15:0] rd_q = 16'h0000;
	logic [15:0] pdata = 16'h0000;
	logic [7:0] sel = 8'h00;
	logic [3:0] ucyc = 4'h0;
	logic t6 = 1'b0, t2 = 1'b0, tl = 1'b0, pf = 1'b0, we_q = 1'b1, oe_q = 1'b1;
	int cnt = 0;
	wire logic [7:0] idx = {flash_addr[18:16], flash_addr[4:0]};
	wire logic insel = sel[flash_addr[18:16]];
	wire logic [7:0] wd = flash_dq_out[7:0];

	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 16'hFFFF;
	end

	// Open drain with pull-up, low while busy
	assign ready_busy_output = !(mode inside {PROG, WINDOW, ERASING});
	// Released bus shows the inverse of the last word so stale data never passes
	assign flash_dq_in = flash_dq_oe ? flash_dq_out : (!flash_ce_n && !flash_oe_n) ? rd_q : ~rd_q;

	always @(posedge clk_sys) begin
		we_q <= flash_we_n;
		oe_q <= flash_oe_n;
		// Timer frozen in suspend so the erase resumes where it stopped
		if (cnt != 0 && mode != SUSP) begin
			cnt <= cnt - 1;
		end else if (mode == PROG && !tl) begin
			if (pf) tl <= 1'b1;
			else mode <= ARRAY;
		end else if (mode == WINDOW) begin
			mode <= ERASING;
			cnt <= ERASE_CYC;
		end else if (mode == ERASING && cnt == 0) begin
			for (int i = 0; i < 256; i++) if (sel[i / 32]) mem[i] <= 16'hFFFF;
			sel <= 8'h00;
			mode <= ARRAY;
		end
		if (oe_q && !flash_oe_n && !flash_ce_n) begin
			if (mode == ARRAY || (mode == SUSP && !insel)) rd_q <= mem[idx];
			else rd_q <= {8'h00, (mode == PROG) ? ~pdata[7] : (mode == SUSP), t6, tl, 1'b0,
				mode == ERASING, t2, 2'b00};
			t6 <= t6 ^ (mode inside {PROG, WINDOW, ERASING});
			t2 <= t2 ^ (insel && mode inside {WINDOW, ERASING, SUSP});
		end
		if (we_q && !flash_we_n && !flash_ce_n) begin
			if (wd == 8'hF0 && (mode == ARRAY || tl)) begin
				mode <= ARRAY;
				tl <= 1'b0;
				ucyc <= 4'h0;
				cnt <= 0;
			end else if (mode == WINDOW && wd == 8'h30) begin
				sel[flash_addr[18:16]] <= 1'b1;
				cnt <= WIN_CYC;
			end else if (mode == ERASING && wd == 8'hB0) begin
				mode <= SUSP;
			end else if (mode == SUSP && wd == 8'h30) begin
				mode <= ERASING;
			end else if (mode == ARRAY) begin
				ucyc <= 4'h0;
				case (ucyc)
					4'h0: if (wd == 8'hAA) ucyc <= 4'h1;
					4'h1, 4'h4: if (wd == 8'h55) ucyc <= ucyc + 4'h1;
					4'h2: ucyc <= (wd == 8'hA0) ? 4'h9 : (wd == 8'h80) ? 4'h3 : 4'h0;
					4'h3: if (wd == 8'hAA) ucyc <= 4'h4;
					4'h5: if (wd == 8'h30) begin
						sel[flash_addr[18:16]] <= 1'b1;
						mode <= WINDOW;
						cnt <= WIN_CYC;
					end else if (wd == 8'h10) begin
						sel <= 8'hFF;
						mode <= ERASING;
						cnt <= ERASE_CYC;
					end
					4'h9: begin
						pdata <= flash_dq_out;
						pf <= |(flash_dq_out & ~mem[idx]);
						mem[idx] <= mem[idx] & flash_dq_out;
						mode <= PROG;
						cnt <= PROG_CYC;
					end
					default: ;
				endcase
			end
		end
	end
endmodule

// ===== sim/flash_status_host_tb.sv
// Self-checking bench for the flash status host against a device model
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; $display("BAD %0t got %h want %h", $time, a, b); end end
module flash_status_host_tb;
	typedef struct {logic [15:0] d; bit cd; logic f; logic r;} exp_t;
	logic clk_sys = 1'b0, reset_n = 1'b0, cmd_valid = 1'b0;
	flash_host_pkg::op_t cmd_op = flash_host_pkg::OP_READ;
	logic [18:0] cmd_addr = 19'h00000, pa, ua, flash_addr;
	logic [15:0] cmd_data = 16'h0000, pd, ud, rd_data, flash_dq_out, flash_dq_in;
	logic cmd_ready, done, failed, rejected, dev_busy, flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n;
	logic ready_busy_output;
	int n_fail = 0, checks = 0;
	exp_t exq[$];
	exp_t e;

	always #2.5 clk_sys = ~clk_sys;

	// Long enough that a follow-up right after the acceptance poll takes the unchecked path
	flash_status_host #(.SKIP_CYCLES(100)) uut (.clk_sys(clk_sys), .reset_n(reset_n), .cmd_valid(cmd_valid),
		.cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready), .done(done),
		.failed(failed), .rejected(rejected), .rd_data(rd_data), .dev_busy(dev_busy), .flash_addr(flash_addr),
		.flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in),
		.flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
		.ready_busy_output(ready_busy_output));

	flash_device_model dev (.clk_sys(clk_sys), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
		.flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
		.flash_dq_in(flash_dq_in), .ready_busy_output(ready_busy_output));

	task automatic end_of_test;
		$display("Mismatches %0d, checks %0d", n_fail, checks);
		if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// Notes the expectation first, then issues one command and waits for its done pulse
	task automatic op(input flash_host_pkg::op_t o, input logic [18:0] a, input logic [15:0] d,
		input logic ef, input logic er, input bit cd = 1'b0, input logic [15:0] ed = 16'h0000);
		int n;
		n = 0;
		exq.push_back('{ed, cd, ef, er});
		@(negedge clk_sys);
		while (cmd_ready !== 1'b1) @(negedge clk_sys);
		cmd_valid = 1'b1;
		cmd_op = o;
		cmd_addr = a;
		cmd_data = d;
		@(negedge clk_sys);
		cmd_valid = 1'b0;
		while (done !== 1'b1 && n < 20000) begin
			@(negedge clk_sys);
			n++;
		end
		if (n == 20000) begin
			n_fail++;
			$display("BAD %0t no done", $time);
		end
	endtask

	task automatic rd(input logic [18:0] a, input logic [15:0] ed);
		op(flash_host_pkg::OP_READ, a, 16'h0000, 1'b0, 1'b0, 1'b1, ed);
	endtask

	always @(negedge clk_sys) begin
		if (done === 1'b1) begin
			if (exq.size() == 0) begin
				n_fail++;
				$display("BAD %0t unexpected done", $time);
			end else begin
				e = exq.pop_front();
				`CHK(failed, e.f)
				`CHK(rejected, e.r)
				if (e.cd) `CHK(rd_data, e.d)
			end
		end
	end

	initial begin
		repeat (60000) @(posedge clk_sys);
		n_fail++;
		$display("BAD %0t watchdog expired", $time);
		end_of_test();
	end

	initial begin
		void'($urandom(32'h1FDEB9F9));
		pd = 16'($urandom);
		pd[0] = 1'b0;
		ud = 16'($urandom);
		pa = {3'h1, 11'h000, 5'($urandom)};
		ua = {3'h5, 11'h000, 5'($urandom)};
		repeat (10) @(negedge clk_sys);
		reset_n = 1'b1;
		rd(pa, 16'hFFFF);
		op(flash_host_pkg::OP_PROGRAM, pa, pd, 1'b0, 1'b0);
		rd(pa, pd);
		// Bit 0 goes back to 1, which only erase can do
		op(flash_host_pkg::OP_PROGRAM, pa, ~pd, 1'b1, 1'b0);
		rd(pa, 16'h0000);
		op(flash_host_pkg::OP_PROGRAM, ua, ud, 1'b0, 1'b0);
		op(flash_host_pkg::OP_CHIP_ERASE, pa, 16'h0000, 1'b0, 1'b0);
		rd(ua, 16'hFFFF);
		op(flash_host_pkg::OP_PROGRAM, ua, ud, 1'b0, 1'b0);
		op(flash_host_pkg::OP_PROGRAM, pa, pd, 1'b0, 1'b0);
		op(flash_host_pkg::OP_SECTOR_ERASE, pa, 16'h0000, 1'b0, 1'b0);
		// Close follow-up goes out without window checks
		op(flash_host_pkg::OP_ADD_SECTOR, ua, 16'h0000, 1'b0, 1'b0);
		repeat (100) @(negedge clk_sys);
		op(flash_host_pkg::OP_ADD_SECTOR, 19'h30000, 16'h0000, 1'b0, 1'b0);
		op(flash_host_pkg::OP_WAIT, pa, 16'h0000, 1'b0, 1'b0);
		rd(ua, 16'hFFFF);
		rd(pa, 16'hFFFF);
		op(flash_host_pkg::OP_PROGRAM, ua, ud, 1'b0, 1'b0);
		op(flash_host_pkg::OP_PROGRAM, pa, pd, 1'b0, 1'b0);
		op(flash_host_pkg::OP_SECTOR_ERASE, pa, 16'h0000, 1'b0, 1'b0);
		// Idle past the acceptance window so erasure has begun
		repeat (400) @(negedge clk_sys);
		op(flash_host_pkg::OP_ADD_SECTOR, ua, 16'h0000, 1'b0, 1'b1);
		`CHK(dev_busy, 1'b1)
		op(flash_host_pkg::OP_SUSPEND, pa, 16'h0000, 1'b0, 1'b0);
		`CHK(dev_busy, 1'b0)
		rd(ua, ud);
		op(flash_host_pkg::OP_RESUME, pa, 16'h0000, 1'b0, 1'b0);
		rd(pa, 16'hFFFF);
		rd(ua, ud);
		op(flash_host_pkg::OP_RESET, pa, 16'h0000, 1'b0, 1'b0);
		rd(pa, 16'hFFFF);
		end_of_test();
	end
endmodule
